// >>> common/serial_dac_defines.vh
// Constants for the serial DAC command interface
`ifndef SERIAL_DAC_DEFINES_VH
`define SERIAL_DAC_DEFINES_VH
`define SHIFT_LEN 32
`define CMD_MSB 23
`define CMD_LSB 20
`define DATA_MSB 15
`define DATA_LSB 0
`define CMD_WRITE 4'h0
`define CMD_UPDATE 4'h1
`define CMD_WRITE_UPDATE 4'h3
`define CMD_POWER_DOWN 4'h4
`define CMD_NOP 4'hf
`define CODE_ZERO 16'h0000
`define CODE_MIDSCALE 16'h8000
`define REF_CLK_MHZ 250
`define SETTLE_5V_US 12
`define SETTLE_3V_US 30
`define SYNC_IDLE 5'h07
`endif

// >>> core/pin_sync.v
// Two-flop synchroniser for a group of input pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire ref_clk_in,
   input wire rstn_in,
   input wire [WIDTH-1:0] pins_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;
   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta <= pins_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> core/serial_dac_core.v
// Serial command interface of a single voltage-output DAC
// Operation
// - Data-out shows bit from 32 rising clocks ago, changed on falling clock edge.
// - Code 0000 writes data word into input register only.
// - Code 0001 copies input register to DAC register and powers up.
// - Code 0011 writes input register, updates DAC register, powers up.
// - Code 0100 enters power-down; data word ignored.
// - Code 1111 does nothing; host sends it to other chained devices.
// - Command executes on select rising edge, shared by all chained devices.
// - Power-down leaves input and DAC registers unchanged.
// - Any update, command or pin, leaves power-down.
// - Output flagged unsettled 12us (5V) or 30us (3V) after power-up.
// - Update pin low while select high copies input to DAC register.
// - Update pulse starting while select low powers up, no update.
// - Update pin low at select rise: execute command, then update.
// - Update pin low always powers up.
// - Update pin low at select rise blocks power-down command.
// - Word: 4 command bits, 4 don't-care, 16 data MSB first; shift while select low.
// - Clear pin low forces registers to zero or midscale code.
`timescale 1ns/1ps
`default_nettype none
`include "serial_dac_defines.vh"
module serial_dac_core #(
   parameter MIDSCALE_VARIANT = 0,
   parameter SETTLE_5V_CYCLES = `SETTLE_5V_US * `REF_CLK_MHZ,
   parameter SETTLE_3V_CYCLES = `SETTLE_3V_US * `REF_CLK_MHZ
) (
   input wire ref_clk_in,
   input wire rstn_in,
   input wire serial_clk_in,
   input wire serial_data_in,
   input wire select_and_load_n_in,
   input wire async_update_n_in,
   input wire async_clear_n_in,
   input wire supply_is_3v_in,
   output reg serial_data_out,
   output reg [15:0] input_code_out,
   output reg [15:0] dac_code_out,
   output reg powered_down_out,
   output reg settled_out
);
   localparam [15:0] CLEAR_CODE = MIDSCALE_VARIANT ? `CODE_MIDSCALE : `CODE_ZERO;
   localparam [31:0] LONG_SETTLE = SETTLE_3V_CYCLES;
   localparam [31:0] SHORT_SETTLE = SETTLE_5V_CYCLES;
   localparam PD_ACTIVE = 1'b0;
   localparam PD_DOWN = 1'b1;

   // Synchronised pins and edges
   wire [4:0] pin_group;
   wire [4:0] sync;
   wire sclk;
   wire sdi;
   wire sel_n;
   wire upd_n;
   wire clr_n;
   reg sclk_d;
   reg sel_d;
   reg upd_d;
   wire sclk_rise;
   wire sclk_fall;
   wire sel_rise;
   wire upd_fall;
   wire shift_en;

   // Command decode
   reg [`SHIFT_LEN-1:0] shifter;
   wire [3:0] cmd;
   wire [15:0] data_word;
   wire is_write;
   wire is_update;
   wire is_write_update;
   wire is_power_down;
   wire loads_input;
   wire updates_dac;
   wire pd_allowed;
   wire upd_held;
   wire pin_copy;
   wire wake;

   // Next-state terms
   reg [31:0] settle_cnt;
   reg [31:0] next_settle_cnt;
   wire [31:0] settle_load;
   reg next_settled;
   reg [15:0] next_input;
   reg [15:0] next_dac;
   reg next_pd;
   reg next_out_bit;
   reg pu_event;

   // Two-flop synchronisers on every pin input except supply_is_3v_in
   assign pin_group = {serial_clk_in, serial_data_in, select_and_load_n_in,
      async_update_n_in, async_clear_n_in};
   pin_sync #(
      .WIDTH(5),
      .INIT(`SYNC_IDLE)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .pins_in(pin_group),
      .sync_out(sync)
   );

   // Pin views after synchronisation
   assign sclk = sync[4];
   assign sdi = sync[3];
   assign sel_n = sync[2];
   assign upd_n = sync[1];
   assign clr_n = sync[0];

   // Edges of the synchronised pins
   assign sclk_rise = sclk & ~sclk_d;
   assign sclk_fall = ~sclk & sclk_d;
   assign sel_rise = sel_n & ~sel_d;
   assign upd_fall = ~upd_n & upd_d;
   assign shift_en = sclk_rise & ~sel_n;

   // Command word fields
   assign cmd = shifter[`CMD_MSB:`CMD_LSB];
   assign data_word = shifter[`DATA_MSB:`DATA_LSB];

   // Command decode; reserved codes and no-op decode to nothing
   assign is_write = (cmd == `CMD_WRITE);
   assign is_update = (cmd == `CMD_UPDATE);
   assign is_write_update = (cmd == `CMD_WRITE_UPDATE);
   assign is_power_down = (cmd == `CMD_POWER_DOWN);
   assign loads_input = is_write | is_write_update;
   assign updates_dac = is_update | is_write_update;
   assign upd_held = ~upd_n;
   assign pd_allowed = is_power_down & upd_n;
   assign pin_copy = sel_n & ~upd_n;
   assign wake = upd_fall;
   assign settle_load = supply_is_3v_in ? LONG_SETTLE : SHORT_SETTLE;

   // Next contents of input and DAC registers
   always @*
   begin
      next_input = input_code_out;
      next_dac = dac_code_out;
      if (sel_rise)
      begin
         if (loads_input)
         begin
            next_input = data_word;
         end
         if (updates_dac)
         begin
            next_dac = loads_input ? data_word : input_code_out;
         end
         if (upd_held)
         begin
            next_dac = loads_input ? data_word : input_code_out;
         end
      end
      else if (pin_copy)
      begin
         next_dac = input_code_out;
      end
   end

   // Power state: active or powered down
   always @*
   begin
      next_pd = powered_down_out;
      pu_event = 1'b0;
      case (powered_down_out)
         PD_ACTIVE:
         begin
            if (sel_rise && pd_allowed)
            begin
               next_pd = PD_DOWN;
            end
         end
         PD_DOWN:
         begin
            if (wake)
            begin
               next_pd = PD_ACTIVE;
               pu_event = 1'b1;
            end
            else if (sel_rise && (updates_dac || upd_held))
            begin
               next_pd = PD_ACTIVE;
               pu_event = 1'b1;
            end
            else if (!sel_rise && pin_copy)
            begin
               next_pd = PD_ACTIVE;
               pu_event = 1'b1;
            end
         end
         default:
         begin
            next_pd = PD_ACTIVE;
         end
      endcase
   end

   // Daisy-chain output bit
   always @*
   begin
      next_out_bit = serial_data_out;
      if (sclk_fall)
      begin
         next_out_bit = shifter[`SHIFT_LEN-1];
      end
   end

   // Settling counter, loaded on leaving power-down
   always @*
   begin
      next_settle_cnt = settle_cnt;
      if (pu_event && powered_down_out)
      begin
         next_settle_cnt = settle_load;
      end
      else if (settle_cnt != 32'h0)
      begin
         next_settle_cnt = settle_cnt - 32'h1;
      end
      next_settled = (next_settle_cnt == 32'h0);
   end

   // Pin edge history
   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sclk_d <= 1'b0;
         sel_d <= 1'b1;
         upd_d <= 1'b1;
      end
      else
      begin
         sclk_d <= sclk;
         sel_d <= sel_n;
         upd_d <= upd_n;
      end
   end

   // Input shift register and serial output
   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         shifter <= {`SHIFT_LEN{1'b0}};
         serial_data_out <= 1'b0;
      end
      else
      begin
         if (shift_en)
         begin
            shifter <= {shifter[`SHIFT_LEN-2:0], sdi};
         end
         serial_data_out <= next_out_bit;
      end
   end

   // Input and DAC registers; clear wins over every write
   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         input_code_out <= CLEAR_CODE;
         dac_code_out <= CLEAR_CODE;
      end
      else if (!clr_n)
      begin
         input_code_out <= CLEAR_CODE;
         dac_code_out <= CLEAR_CODE;
      end
      else
      begin
         input_code_out <= next_input;
         dac_code_out <= next_dac;
      end
   end

   // Power state and settling counter
   always @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         powered_down_out <= PD_ACTIVE;
         settle_cnt <= 32'h0;
         settled_out <= 1'b1;
      end
      else
      begin
         powered_down_out <= next_pd;
         settle_cnt <= next_settle_cnt;
         settled_out <= next_settled;
      end
   end
endmodule
`default_nettype wire

// >>> verif/serial_dac_chk.sv
// Assertions on the DAC core ports
`timescale 1ns/1ps
`default_nettype none
module serial_dac_chk (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic serial_clk_in,
   input wire logic select_and_load_n_in,
   input wire logic async_update_n_in,
   input wire logic async_clear_n_in,
   input wire logic serial_data_out,
   input wire logic powered_down_out,
   input wire logic settled_out,
   input wire logic [15:0] input_code_out,
   input wire logic [15:0] dac_code_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   pd_keep_a: assert property ($rose(powered_down_out) |->
      $stable(input_code_out) && $stable(dac_code_out)) else $error("pd codes");
   pd_load_a: assert property ($rose(powered_down_out) |-> select_and_load_n_in)
      else $error("pd in frame");
   clear_zero_a: assert property (!async_clear_n_in [*6] |->
      input_code_out == 16'h0 && dac_code_out == 16'h0) else $error("clear");
   pin_copy_a: assert property ((select_and_load_n_in && !async_update_n_in) [*7] |->
      dac_code_out == input_code_out) else $error("no copy");
   pin_wake_a: assert property (!async_update_n_in [*6] |-> !powered_down_out)
      else $error("no wake");
   settle_low_a: assert property ($fell(powered_down_out) |-> ##2 !settled_out [*8])
      else $error("settle");
   frame_hold_a: assert property ((!select_and_load_n_in && async_clear_n_in) [*6] |->
      $stable(dac_code_out)) else $error("frame");
   sdo_edge_a: assert property ($changed(serial_data_out) |->
      !serial_clk_in && $past(serial_clk_in, 3) == 1'h0) else $error("sdo");
   cover property ($rose(powered_down_out));
   cover property ($fell(settled_out));
   cover property (select_and_load_n_in && !async_update_n_in);
endmodule
`default_nettype wire

// >>> verif/serial_dac_command_interface_test.sv
// Bench for the serial DAC command interface
`timescale 1ns/1ps
`default_nettype none
module serial_dac_command_interface_test;
   localparam int SHORT_CYC = 20;
   localparam int LONG_CYC = 50;
   logic clk = 1'h0, rstn = 1'h0, upd = 1'h1, clr = 1'h1, s3v = 1'h1;
   int sn = 0;
   logic [32:0] ex = 33'h0;
   logic [32:0] q[$];
   logic [31:0] seed = 32'ha2cf;
   logic [3:0] cs[5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hf};
   int err_count = 0, num_checks = 0;
   wire sck, sdi, sel_n, pd, sdo, st;
   wire [15:0] ic, dc;
   serial_host u_host (.sdo_in(sdo), .sclk_out(sck), .sdi_out(sdi), .sel_n_out(sel_n));
   serial_dac_core #(.SETTLE_5V_CYCLES(SHORT_CYC), .SETTLE_3V_CYCLES(LONG_CYC)) u_dut (
      .ref_clk_in(clk), .rstn_in(rstn), .serial_clk_in(sck), .serial_data_in(sdi),
      .select_and_load_n_in(sel_n), .async_update_n_in(upd), .async_clear_n_in(clr),
      .supply_is_3v_in(s3v), .serial_data_out(sdo), .input_code_out(ic), .dac_code_out(dc),
      .powered_down_out(pd), .settled_out(st));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [32:0] s, input logic [32:0] x);
      num_checks++;
      if (s !== x)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmd(input logic [3:0] c, input int n);
      seed = lfsr(seed);
      if (c == 4'h0 || c == 4'h3)
         ex[31:16] = seed[15:0];
      if (c == 4'h1 || c == 4'h3 || !upd)
         ex = {1'h0, ex[31:16], ex[31:16]};
      if (c == 4'h4 && upd)
         ex[32] = 1'h1;
      q.push_back(ex);
      u_host.send({seed, seed[31:24], c, seed[19:0]}, n);
   endtask
   task automatic pulse(ref logic p, input logic [32:0] x);
      @(posedge clk) #1 p = 1'h0;
      repeat (10) @(posedge clk);
      ex = x;
      q.push_back(ex);
      #1 p = 1'h1;
      repeat (12) @(posedge clk);
   endtask
   initial
   begin
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (50000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   initial
   begin
      #50;
      forever
      begin
         @(posedge sel_n or posedge upd or posedge clr);
         repeat (8) @(posedge clk);
         #1;
         chk({pd, ic, dc}, q.pop_front());
      end
   end
   initial
   begin
      #50;
      forever
      begin
         @(negedge st);
         sn = 0;
         do
         begin
            @(posedge clk) #1;
            sn++;
         end
         while (st !== 1'h1 && sn < 1000);
         chk(sn, s3v ? LONG_CYC : SHORT_CYC);
      end
   end
   initial
   begin
      #11 rstn = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      repeat (2) foreach (cs[k]) cmd(cs[k], 32);
      cmd(4'h1, 64);
      chk(u_host.seen, seed);
      cmd(4'h3, 24);
      @(posedge clk) #1 s3v = 1'h0;
      cmd(4'h4, 32);
      cmd(4'h0, 32);
      pulse(upd, {1'h0, ex[31:16], ex[31:16]});
      @(posedge clk) #1 upd = 1'h0;
      cmd(4'h4, 32);
      cmd(4'h0, 24);
      q.push_back(ex);
      @(posedge clk) #1 upd = 1'h1;
      repeat (12) @(posedge clk);
      pulse(clr, {ex[32], 32'h0});
      print_verdict();
   end
endmodule
bind serial_dac_core serial_dac_chk u_chk (.*);
`default_nettype wire

// >>> verif/serial_host.sv
// Host model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   input wire logic sdo_in,
   output var logic sclk_out = 1'h0,
   output var logic sdi_out = 1'h0,
   output var logic sel_n_out = 1'h1
);
   logic [31:0] seen = 32'h0;
   // Clock rests low, data inverts between frames; data-out sampled at each rise
   task automatic send(input logic [63:0] w, input int n);
      sel_n_out = 1'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi_out = w[i];
         #40 seen = {seen[30:0], sdo_in};
         sclk_out = 1'h1;
         #40 sclk_out = 1'h0;
      end
      #40 sdi_out = ~sdi_out;
      sel_n_out = 1'h1;
      #200;
   endtask
endmodule
`default_nettype wire
